// *** logic/pifb_avmm_slave.sv ***
// Avalon-MM slave with waitrequest, one access per two cycles
`timescale 1ns/100ps
module pifb_avmm_slave
    import pifb_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Avalon-MM
    input wire logic [AW-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [DW-1:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [DW-1:0] readdata_o,
    output logic waitrequest_o,
    // Register side
    pifb_reg_if.bus rg
);

    typedef enum logic {SL_IDLE, SL_ACK} pifb_sl_state_t;

    typedef struct packed {
        pifb_sl_state_t state;
        logic waitrequest;
        logic [DW-1:0] readdata;
    } pifb_slave_t;

    pifb_slave_t state_q, state_d;

    always_comb begin
        state_d = state_q;
        rg.wr_stb = 1'b0;
        rg.addr = address_i;
        rg.wdata = writedata_i[RW-1:0];
        unique case (state_q.state)
            SL_IDLE: begin
                if (read_i || write_i) begin
                    state_d.state = SL_ACK;
                    state_d.waitrequest = 1'b0;
                    state_d.readdata = read_i ? {24'h000000, rg.rdata}
                                              : 32'h00000000;
                end
            end
            SL_ACK: begin
                // Write lands on the edge that sees waitrequest low
                rg.wr_stb = write_i & byteenable_i[0];
                state_d.state = SL_IDLE;
                state_d.waitrequest = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= '{state: SL_IDLE, waitrequest: 1'b1,
                         readdata: 32'h00000000};
        end else begin
            state_q <= state_d;
        end
    end

    assign readdata_o = state_q.readdata;
    assign waitrequest_o = state_q.waitrequest;

endmodule // pifb_avmm_slave

// *** logic/pifb_bank.sv ***
// Top: peripheral interrupt flag and enable bank behind Avalon-MM
`timescale 1ns/100ps

// Function
// - Clock fail sets bit 7, software zero clears
// - Comparator 2/1 changes set bits 6/5
// - System event bit 4 always reads zero
// - Port one collision sets bit 3
// - Voltage detector trip sets bit 2
// - Timer 3 overflow sets bit 1
// - Capture unit two flags, never in PWM
// - Uart two rx flag follows buffer full
// - Uart two tx flag follows buffer empty
// - Port two done bit 7, collision bit 6
// - Timer 4 period match sets bit 3
// - Charge measurement event sets bit 2
// - Timer 3 gate completion sets bit 1
// - Calendar event sets bit 0
// - Capture units 3..10 flags, none in PWM
// - Comparator 3 change sets bit 5
// - Timer 8 bit 4, timer 6 bit 3
// - Timer 5 overflow sets bit 2
// - Timer 5 and 1 gate bits 1, 0
// - Timer 2 match bit 1, timer 1 bit 0
// - Enable bits gate; global or priority enable passes the request
// - Parallel port bit 7 absent on small package
// - Flags set regardless of any enable
module pifb_bank
    import pifb_pkg::*;
#(
    parameter bit SMALL_PACKAGE = 1'b0
) (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    // Avalon-MM slave
    input wire logic [AW-1:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [DW-1:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [DW-1:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // First flag register sources
    input wire logic PARALLEL_PORT_EVT_I,
    input wire logic ADC_DONE_EVT_I,
    input wire logic UART_ONE_RX_FULL_I,
    input wire logic UART_ONE_TX_EMPTY_I,
    input wire logic SYNC_ONE_DONE_EVT_I,
    input wire logic CAPTURE_ONE_EVT_I,
    input wire logic TIMER_TWO_MATCH_EVT_I,
    input wire logic TIMER_ONE_OVERFLOW_EVT_I,
    // System event sources
    input wire logic CLOCK_FAIL_EVT_I,
    input wire logic COMPARATOR_TWO_EVT_I,
    input wire logic COMPARATOR_ONE_EVT_I,
    input wire logic COLLISION_ONE_EVT_I,
    input wire logic VOLTAGE_DETECT_EVT_I,
    input wire logic TIMER_THREE_OVERFLOW_EVT_I,
    // Serial and misc sources
    input wire logic SYNC_TWO_DONE_EVT_I,
    input wire logic COLLISION_TWO_EVT_I,
    input wire logic UART_TWO_RX_FULL_I,
    input wire logic UART_TWO_TX_EMPTY_I,
    input wire logic TIMER_FOUR_MATCH_EVT_I,
    input wire logic CHARGE_MEASURE_EVT_I,
    input wire logic TIMER_THREE_GATE_EVT_I,
    input wire logic CALENDAR_EVT_I,
    // Capture units 2..10, unit 2 in bit 0
    input wire logic [CAPTURE_UNITS-1:0] CAPTURE_EVT_I,
    input wire logic [CAPTURE_UNITS-1:0] CAPTURE_PWM_MODE_I,
    // Timer and comparator sources
    input wire logic COMPARATOR_THREE_EVT_I,
    input wire logic TIMER_EIGHT_MATCH_EVT_I,
    input wire logic TIMER_SIX_MATCH_EVT_I,
    input wire logic TIMER_FIVE_OVERFLOW_EVT_I,
    input wire logic TIMER_FIVE_GATE_EVT_I,
    input wire logic TIMER_ONE_GATE_EVT_I,
    // Request to the CPU interrupt logic
    output logic PERIPH_IRQ_O
);

    // ==========================================================
    // Constants and state

    // Parallel port bit disappears on the small package
    localparam logic [RW-1:0] FA_IMPL_MASK =
        SMALL_PACKAGE ? 8'h7f : 8'hff;

    typedef struct packed {
        logic [RW-1:0] enable_a;
        logic global_en;
        logic priority_en;
        logic irq;
    } pifb_top_t;

    pifb_top_t state_q, state_d;

    pifb_reg_if rg ();

    logic [RW-1:0] set_fa, lvl_fa, set_se, set_sm, lvl_sm, set_cb, set_tc;
    logic [CAPTURE_UNITS-1:0] capture_live;
    logic [RW-1:0] flags_fa, flags_se, flags_sm, flags_cb, flags_tc;
    logic wr_fa, wr_se, wr_sm, wr_cb, wr_tc, wr_en, wr_ctl;

    // ==========================================================
    // Bus slave

    pifb_avmm_slave u_slave (
        .clk_i(REF_CLK_I),
        .rst_n_i(NRST_I),
        .address_i(AVS_ADDRESS_I),
        .read_i(AVS_READ_I),
        .write_i(AVS_WRITE_I),
        .writedata_i(AVS_WRITEDATA_I),
        .byteenable_i(AVS_BYTEENABLE_I),
        .readdata_o(AVS_READDATA_O),
        .waitrequest_o(AVS_WAITREQUEST_O),
        .rg(rg.bus)
    );

    // ==========================================================
    // Source mapping
    // Flags see raw sources; enables only act on the request

    // Capture and compare events are dropped while a unit runs PWM
    assign capture_live = CAPTURE_EVT_I & ~CAPTURE_PWM_MODE_I;

    always_comb begin
        set_fa = 8'h00;
        lvl_fa = 8'h00;
        set_fa[FA_PARALLEL_BIT] = PARALLEL_PORT_EVT_I;
        set_fa[FA_ADC_BIT] = ADC_DONE_EVT_I;
        lvl_fa[FA_UART_ONE_RX_BIT] = UART_ONE_RX_FULL_I;
        lvl_fa[FA_UART_ONE_TX_BIT] = UART_ONE_TX_EMPTY_I;
        set_fa[FA_SYNC_ONE_BIT] = SYNC_ONE_DONE_EVT_I;
        set_fa[FA_CAPTURE_ONE_BIT] = CAPTURE_ONE_EVT_I;
        set_fa[FA_TIMER_TWO_BIT] = TIMER_TWO_MATCH_EVT_I;
        set_fa[FA_TIMER_ONE_BIT] = TIMER_ONE_OVERFLOW_EVT_I;
    end

    always_comb begin
        set_se = 8'h00;
        set_se[SE_CLOCK_FAIL_BIT] = CLOCK_FAIL_EVT_I;
        set_se[SE_COMPARATOR_TWO_BIT] = COMPARATOR_TWO_EVT_I;
        set_se[SE_COMPARATOR_ONE_BIT] = COMPARATOR_ONE_EVT_I;
        set_se[SE_COLLISION_ONE_BIT] = COLLISION_ONE_EVT_I;
        set_se[SE_VOLTAGE_BIT] = VOLTAGE_DETECT_EVT_I;
        set_se[SE_TIMER_THREE_BIT] = TIMER_THREE_OVERFLOW_EVT_I;
        set_se[SE_CAPTURE_TWO_BIT] = capture_live[0];
    end

    always_comb begin
        set_sm = 8'h00;
        lvl_sm = 8'h00;
        set_sm[SM_SYNC_TWO_BIT] = SYNC_TWO_DONE_EVT_I;
        set_sm[SM_COLLISION_TWO_BIT] = COLLISION_TWO_EVT_I;
        // Buffer state is owned by the port; the flag only mirrors it
        lvl_sm[SM_UART_TWO_RX_BIT] = UART_TWO_RX_FULL_I;
        lvl_sm[SM_UART_TWO_TX_BIT] = UART_TWO_TX_EMPTY_I;
        set_sm[SM_TIMER_FOUR_BIT] = TIMER_FOUR_MATCH_EVT_I;
        set_sm[SM_CHARGE_BIT] = CHARGE_MEASURE_EVT_I;
        set_sm[SM_TIMER_THREE_GATE_BIT] = TIMER_THREE_GATE_EVT_I;
        set_sm[SM_CALENDAR_BIT] = CALENDAR_EVT_I;
    end

    // Units 10..3 fill bits 7..0
    assign set_cb = capture_live[CAPTURE_UNITS-1:1];

    always_comb begin
        set_tc = 8'h00;
        set_tc[TC_COMPARATOR_THREE_BIT] = COMPARATOR_THREE_EVT_I;
        set_tc[TC_TIMER_EIGHT_BIT] = TIMER_EIGHT_MATCH_EVT_I;
        set_tc[TC_TIMER_SIX_BIT] = TIMER_SIX_MATCH_EVT_I;
        // Owned by timer 5, whatever its legacy label says
        set_tc[TC_TIMER_FIVE_BIT] = TIMER_FIVE_OVERFLOW_EVT_I;
        set_tc[TC_TIMER_FIVE_GATE_BIT] = TIMER_FIVE_GATE_EVT_I;
        set_tc[TC_TIMER_ONE_GATE_BIT] = TIMER_ONE_GATE_EVT_I;
    end

    // ==========================================================
    // Write decode

    assign wr_fa = rg.wr_stb & reg_hit(rg.addr, IDX_PERIPHERAL_FLAGS_A);
    assign wr_se = rg.wr_stb & reg_hit(rg.addr, IDX_SYSTEM_EVENT_FLAGS);
    assign wr_sm = rg.wr_stb & reg_hit(rg.addr, IDX_SERIAL_MISC_FLAGS);
    assign wr_cb = rg.wr_stb & reg_hit(rg.addr, IDX_CAPTURE_FLAGS_B);
    assign wr_tc = rg.wr_stb & reg_hit(rg.addr, IDX_TIMER_COMPARATOR_FLAGS);
    assign wr_en = rg.wr_stb & reg_hit(rg.addr, IDX_PERIPHERAL_ENABLE_A);
    assign wr_ctl = rg.wr_stb & reg_hit(rg.addr, IDX_INTERRUPT_CONTROL);

    // ==========================================================
    // Flag banks

    pifb_flag_bank #(
        .IMPL_MASK(FA_IMPL_MASK),
        .LEVEL_MASK(FA_LEVEL_MASK)
    ) u_flags_a (
        .clk_i(REF_CLK_I),
        .rst_n_i(NRST_I),
        .set_i(set_fa),
        .level_i(lvl_fa),
        .wr_i(wr_fa),
        .wdata_i(rg.wdata),
        .flags_o(flags_fa)
    );

    // Bit 4 is masked out of existence and always reads zero
    pifb_flag_bank #(
        .IMPL_MASK(SE_IMPL_MASK),
        .LEVEL_MASK(8'h00)
    ) u_flags_se (
        .clk_i(REF_CLK_I),
        .rst_n_i(NRST_I),
        .set_i(set_se),
        .level_i(8'h00),
        .wr_i(wr_se),
        .wdata_i(rg.wdata),
        .flags_o(flags_se)
    );

    pifb_flag_bank #(
        .IMPL_MASK(8'hff),
        .LEVEL_MASK(SM_LEVEL_MASK)
    ) u_flags_sm (
        .clk_i(REF_CLK_I),
        .rst_n_i(NRST_I),
        .set_i(set_sm),
        .level_i(lvl_sm),
        .wr_i(wr_sm),
        .wdata_i(rg.wdata),
        .flags_o(flags_sm)
    );

    pifb_flag_bank #(
        .IMPL_MASK(8'hff),
        .LEVEL_MASK(8'h00)
    ) u_flags_cb (
        .clk_i(REF_CLK_I),
        .rst_n_i(NRST_I),
        .set_i(set_cb),
        .level_i(8'h00),
        .wr_i(wr_cb),
        .wdata_i(rg.wdata),
        .flags_o(flags_cb)
    );

    // Comparator 3 is kept software-clearable so a handler can ack it
    pifb_flag_bank #(
        .IMPL_MASK(TC_IMPL_MASK),
        .LEVEL_MASK(8'h00)
    ) u_flags_tc (
        .clk_i(REF_CLK_I),
        .rst_n_i(NRST_I),
        .set_i(set_tc),
        .level_i(8'h00),
        .wr_i(wr_tc),
        .wdata_i(rg.wdata),
        .flags_o(flags_tc)
    );

    // ==========================================================
    // Read mux; unmapped addresses read zero

    always_comb begin
        rg.rdata = 8'h00;
        if (reg_hit(rg.addr, IDX_PERIPHERAL_FLAGS_A)) begin
            rg.rdata = flags_fa;
        end else if (reg_hit(rg.addr, IDX_SYSTEM_EVENT_FLAGS)) begin
            rg.rdata = flags_se;
        end else if (reg_hit(rg.addr, IDX_SERIAL_MISC_FLAGS)) begin
            rg.rdata = flags_sm;
        end else if (reg_hit(rg.addr, IDX_CAPTURE_FLAGS_B)) begin
            rg.rdata = flags_cb;
        end else if (reg_hit(rg.addr, IDX_TIMER_COMPARATOR_FLAGS)) begin
            rg.rdata = flags_tc;
        end else if (reg_hit(rg.addr, IDX_PERIPHERAL_ENABLE_A)) begin
            rg.rdata = state_q.enable_a;
        end else if (reg_hit(rg.addr, IDX_INTERRUPT_CONTROL)) begin
            rg.rdata[CTL_GLOBAL_EN_BIT] = state_q.global_en;
            rg.rdata[CTL_PRIORITY_BIT] = state_q.priority_en;
        end
    end

    // ==========================================================
    // Enables and request

    always_comb begin
        state_d = state_q;
        if (wr_en) begin
            state_d.enable_a = rg.wdata & FA_IMPL_MASK;
        end
        if (wr_ctl) begin
            state_d.global_en = rg.wdata[CTL_GLOBAL_EN_BIT];
            state_d.priority_en = rg.wdata[CTL_PRIORITY_BIT];
        end
        // Registered so the output is glitch-free; costs one cycle
        state_d.irq = (|(flags_fa & state_q.enable_a)) &
                      (state_q.priority_en | state_q.global_en);
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_q <= '{enable_a: ENABLE_RST, global_en: 1'b0,
                         priority_en: 1'b0, irq: 1'b0};
        end else begin
            state_q <= state_d;
        end
    end

    assign PERIPH_IRQ_O = state_q.irq;

endmodule // pifb_bank

// *** logic/pifb_flag_bank.sv ***
// One eight-bit bank of sticky and level-following interrupt flags
`timescale 1ns/100ps
module pifb_flag_bank
    import pifb_pkg::*;
#(
    parameter logic [RW-1:0] IMPL_MASK = 8'hff,
    parameter logic [RW-1:0] LEVEL_MASK = 8'h00
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Sources
    input wire logic [RW-1:0] set_i,
    input wire logic [RW-1:0] level_i,
    // Software write
    input wire logic wr_i,
    input wire logic [RW-1:0] wdata_i,
    // Flags
    output logic [RW-1:0] flags_o
);

    typedef struct packed {
        logic [RW-1:0] flags;
    } pifb_bank_t;

    pifb_bank_t state_q, state_d;

    always_comb begin
        state_d = state_q;
        if (wr_i) begin
            state_d.flags = wdata_i;
        end
        // A source pulse in the same cycle as a clearing write wins
        state_d.flags = state_d.flags | set_i;
        state_d.flags = (state_d.flags & ~LEVEL_MASK) | (level_i & LEVEL_MASK);
        state_d.flags = state_d.flags & IMPL_MASK;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= '{flags: FLAGS_RST};
        end else begin
            state_q <= state_d;
        end
    end

    assign flags_o = state_q.flags;

endmodule // pifb_flag_bank

// *** logic/pifb_pkg.sv ***
// Package: register map, field positions and reset values of the flag bank
package pifb_pkg;

    // ==========================================================
    // Bus geometry
    localparam int AW = 14;
    localparam int DW = 32;
    localparam int RW = 8;

    // ==========================================================
    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_PERIPHERAL_FLAGS_A = 12'hf9e;
    localparam logic [11:0] IDX_SYSTEM_EVENT_FLAGS = 12'hfa1;
    localparam logic [11:0] IDX_SERIAL_MISC_FLAGS = 12'hfa4;
    localparam logic [11:0] IDX_CAPTURE_FLAGS_B = 12'hf8f;
    localparam logic [11:0] IDX_TIMER_COMPARATOR_FLAGS = 12'hf98;
    localparam logic [11:0] IDX_PERIPHERAL_ENABLE_A = 12'hf9d;
    localparam logic [11:0] IDX_INTERRUPT_CONTROL = 12'hfb0;

    // ==========================================================
    // Reset values
    localparam logic [RW-1:0] FLAGS_RST = 8'h00;
    localparam logic [RW-1:0] ENABLE_RST = 8'h00;

    // ==========================================================
    // First flag register fields
    localparam int FA_PARALLEL_BIT = 7;
    localparam int FA_ADC_BIT = 6;
    localparam int FA_UART_ONE_RX_BIT = 5;
    localparam int FA_UART_ONE_TX_BIT = 4;
    localparam int FA_SYNC_ONE_BIT = 3;
    localparam int FA_CAPTURE_ONE_BIT = 2;
    localparam int FA_TIMER_TWO_BIT = 1;
    localparam int FA_TIMER_ONE_BIT = 0;
    localparam logic [RW-1:0] FA_LEVEL_MASK = 8'h30;

    // ==========================================================
    // System event flag fields
    localparam int SE_CLOCK_FAIL_BIT = 7;
    localparam int SE_COMPARATOR_TWO_BIT = 6;
    localparam int SE_COMPARATOR_ONE_BIT = 5;
    localparam int SE_COLLISION_ONE_BIT = 3;
    localparam int SE_VOLTAGE_BIT = 2;
    localparam int SE_TIMER_THREE_BIT = 1;
    localparam int SE_CAPTURE_TWO_BIT = 0;
    localparam logic [RW-1:0] SE_IMPL_MASK = 8'hef;

    // ==========================================================
    // Serial and misc flag fields
    localparam int SM_SYNC_TWO_BIT = 7;
    localparam int SM_COLLISION_TWO_BIT = 6;
    localparam int SM_UART_TWO_RX_BIT = 5;
    localparam int SM_UART_TWO_TX_BIT = 4;
    localparam int SM_TIMER_FOUR_BIT = 3;
    localparam int SM_CHARGE_BIT = 2;
    localparam int SM_TIMER_THREE_GATE_BIT = 1;
    localparam int SM_CALENDAR_BIT = 0;
    localparam logic [RW-1:0] SM_LEVEL_MASK = 8'h30;

    // ==========================================================
    // Timer and comparator flag fields
    localparam int TC_COMPARATOR_THREE_BIT = 5;
    localparam int TC_TIMER_EIGHT_BIT = 4;
    localparam int TC_TIMER_SIX_BIT = 3;
    localparam int TC_TIMER_FIVE_BIT = 2;
    localparam int TC_TIMER_FIVE_GATE_BIT = 1;
    localparam int TC_TIMER_ONE_GATE_BIT = 0;
    localparam logic [RW-1:0] TC_IMPL_MASK = 8'h3f;

    // ==========================================================
    // Interrupt control fields
    localparam int CTL_GLOBAL_EN_BIT = 0;
    localparam int CTL_PRIORITY_BIT = 1;

    // Capture units 2..10 arrive as one vector, unit 2 in bit 0
    localparam int CAPTURE_UNITS = 9;

    function automatic logic reg_hit(input logic [AW-1:0] addr,
                                     input logic [11:0] idx);
        reg_hit = (addr == {idx, 2'b00});
    endfunction

endpackage

// *** logic/pifb_reg_if.sv ***
// Interface: register strobes between bus slave and flag bank core
`timescale 1ns/100ps
interface pifb_reg_if;
    import pifb_pkg::*;
    logic wr_stb;
    logic [AW-1:0] addr;
    logic [RW-1:0] wdata;
    logic [RW-1:0] rdata;
    modport bus (output wr_stb, output addr, output wdata, input rdata);
    modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface

// *** sim/pifb_bank_bench.sv ***
// Bench: register, flag, level and request scenarios for the bank
`timescale 1ns/100ps
module pifb_bank_bench;
    import pifb_pkg::*;
    localparam logic [11:0] IX [5] = '{IDX_PERIPHERAL_FLAGS_A,
        IDX_SYSTEM_EVENT_FLAGS, IDX_SERIAL_MISC_FLAGS, IDX_CAPTURE_FLAGS_B,
        IDX_TIMER_COMPARATOR_FLAGS};
    localparam logic [7:0] MK [5] = '{8'hcf, 8'hef, 8'hcf, 8'hff, 8'h3f};
    logic clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0, fire = 1'b0;
    logic wreq, irq;
    logic [AW-1:0] adr = '0;
    logic [DW-1:0] wd = '0, rdat;
    logic [5:0] sel = 6'h00;
    logic [39:0] ev;
    logic [3:0] lv = 4'h0;
    logic [8:0] pwm = 9'h000;
    logic [7:0] rq;
    int num_errors = 0, checked = 0;
    always #5 clk = ~clk;

    // ==========
    // Design and event sources
    pifb_evt_model u_src (.clk_i(clk), .rst_n_i(nrst), .fire_i(fire),
        .sel_i(sel), .evt_o(ev));
    pifb_bank dut (.REF_CLK_I(clk), .NRST_I(nrst), .AVS_ADDRESS_I(adr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
        .AVS_BYTEENABLE_I(4'h1), .AVS_READDATA_O(rdat),
        .AVS_WAITREQUEST_O(wreq), .PARALLEL_PORT_EVT_I(ev[7]),
        .ADC_DONE_EVT_I(ev[6]), .UART_ONE_RX_FULL_I(lv[3]),
        .UART_ONE_TX_EMPTY_I(lv[2]), .SYNC_ONE_DONE_EVT_I(ev[3]),
        .CAPTURE_ONE_EVT_I(ev[2]), .TIMER_TWO_MATCH_EVT_I(ev[1]),
        .TIMER_ONE_OVERFLOW_EVT_I(ev[0]), .CLOCK_FAIL_EVT_I(ev[15]),
        .COMPARATOR_TWO_EVT_I(ev[14]), .COMPARATOR_ONE_EVT_I(ev[13]),
        .COLLISION_ONE_EVT_I(ev[11]), .VOLTAGE_DETECT_EVT_I(ev[10]),
        .TIMER_THREE_OVERFLOW_EVT_I(ev[9]), .SYNC_TWO_DONE_EVT_I(ev[23]),
        .COLLISION_TWO_EVT_I(ev[22]), .UART_TWO_RX_FULL_I(lv[1]),
        .UART_TWO_TX_EMPTY_I(lv[0]), .TIMER_FOUR_MATCH_EVT_I(ev[19]),
        .CHARGE_MEASURE_EVT_I(ev[18]), .TIMER_THREE_GATE_EVT_I(ev[17]),
        .CALENDAR_EVT_I(ev[16]), .CAPTURE_EVT_I({ev[31:24], ev[8]}),
        .CAPTURE_PWM_MODE_I(pwm), .COMPARATOR_THREE_EVT_I(ev[37]),
        .TIMER_EIGHT_MATCH_EVT_I(ev[36]), .TIMER_SIX_MATCH_EVT_I(ev[35]),
        .TIMER_FIVE_OVERFLOW_EVT_I(ev[34]), .TIMER_FIVE_GATE_EVT_I(ev[33]),
        .TIMER_ONE_GATE_EVT_I(ev[32]), .PERIPH_IRQ_O(irq));

    // ==========
    // Shared tasks
    task automatic give_verdict();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Holds the request until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [11:0] i,
                       input logic [7:0] d);
        int n;
        @(posedge clk);
        {adr, wd, rd, wr} <= {i, 2'b00, 24'h0, d, !w, w};
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (wreq === 1'b0) break;
        end
        if (n == 50) begin
            num_errors++;
            give_verdict();
        end
        rq = rdat[7:0];
        {rd, wr} <= 2'b00;
    endtask
    task automatic wr8(input logic [11:0] i, input logic [7:0] d);
        bus(1'b1, i, d);
    endtask
    task automatic rd_chk(input logic [11:0] i, input logic [7:0] e);
        bus(1'b0, i, 8'h00);
        check(rq, e);
    endtask
    task automatic pulse(input int s);
        @(posedge clk);
        {sel, fire} <= {s[5:0], 1'b1};
        @(posedge clk);
        fire <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic irq_chk(input logic e);
        repeat (3) @(negedge clk);
        check({7'h00, irq}, {7'h00, e});
    endtask

    // ==========
    // Scenarios
    task automatic t_reset();
        for (int g = 0; g < 5; g++) rd_chk(IX[g], 8'h00);
        rd_chk(IDX_PERIPHERAL_ENABLE_A, 8'h00);
        rd_chk(IDX_INTERRUPT_CONTROL, 8'h00);
        rd_chk(12'h123, 8'h00);
    endtask
    task automatic t_flags();
        for (int g = 0; g < 5; g++) begin
            wr8(IX[g], 8'hff);
            rd_chk(IX[g], MK[g]);
            wr8(IX[g], 8'h00);
            for (int b = 0; b < 8; b++) begin
                if (MK[g][b]) begin
                    pulse(g * 8 + b);
                    rd_chk(IX[g], 8'h01 << b);
                    rd_chk(IX[g], 8'h01 << b);
                    wr8(IX[g], 8'h00);
                    rd_chk(IX[g], 8'h00);
                end
            end
        end
    endtask
    task automatic t_pwm();
        pwm <= 9'h1ff;
        pulse(8);
        for (int b = 24; b < 32; b++) pulse(b);
        rd_chk(IX[1], 8'h00);
        rd_chk(IX[3], 8'h00);
        pwm <= 9'h000;
    endtask
    task automatic t_levels();
        lv <= 4'b1010;
        wr8(IX[2], 8'h00);
        rd_chk(IX[2], 8'h20);
        rd_chk(IX[0], 8'h20);
        lv <= 4'b0101;
        rd_chk(IX[2], 8'h10);
        rd_chk(IX[0], 8'h10);
        lv <= 4'b0000;
    endtask
    task automatic t_irq();
        wr8(IDX_PERIPHERAL_ENABLE_A, 8'h01);
        wr8(IDX_INTERRUPT_CONTROL, 8'h01);
        irq_chk(1'b0);
        pulse(0);
        irq_chk(1'b1);
        wr8(IDX_INTERRUPT_CONTROL, 8'h00);
        irq_chk(1'b0);
        wr8(IDX_INTERRUPT_CONTROL, 8'h02);
        irq_chk(1'b1);
        rd_chk(IDX_INTERRUPT_CONTROL, 8'h02);
        wr8(IDX_PERIPHERAL_ENABLE_A, 8'h00);
        irq_chk(1'b0);
        rd_chk(IX[0], 8'h01);
        wr8(IX[0], 8'h00);
        wr8(IDX_PERIPHERAL_ENABLE_A, 8'h01);
        irq_chk(1'b0);
        wr8(IDX_INTERRUPT_CONTROL, 8'h00);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_flags();
        t_pwm();
        t_levels();
        t_irq();
        give_verdict();
    end
endmodule // pifb_bank_bench

// *** sim/pifb_bank_monitor.sv ***
// Checker: bus timing, read-back and request gating of the bank
`timescale 1ns/100ps
module pifb_bank_monitor
    import pifb_pkg::*;
#(
    parameter bit SMALL_PACKAGE = 1'b0
) (
    // Clock, reset and bus
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic [AW-1:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [DW-1:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    input wire logic [DW-1:0] AVS_READDATA_O,
    input wire logic AVS_WAITREQUEST_O,
    // First flag sources and serial levels
    input wire logic PARALLEL_PORT_EVT_I,
    input wire logic ADC_DONE_EVT_I,
    input wire logic UART_ONE_RX_FULL_I,
    input wire logic UART_ONE_TX_EMPTY_I,
    input wire logic SYNC_ONE_DONE_EVT_I,
    input wire logic CAPTURE_ONE_EVT_I,
    input wire logic TIMER_TWO_MATCH_EVT_I,
    input wire logic TIMER_ONE_OVERFLOW_EVT_I,
    input wire logic UART_TWO_RX_FULL_I,
    input wire logic UART_TWO_TX_EMPTY_I,
    // Request
    input wire logic PERIPH_IRQ_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!NRST_I);

    // ==========
    // Shadow of the first flags, enables and control
    logic [7:0] keep, ev, base, fa_q, en_q;
    logic [1:0] ctl_q;
    logic ack, req;
    assign keep = SMALL_PACKAGE ? 8'h7f : 8'hff;
    assign ack = AVS_WRITE_I & ~AVS_WAITREQUEST_O & AVS_BYTEENABLE_I[0];
    assign ev = {PARALLEL_PORT_EVT_I, ADC_DONE_EVT_I, 2'b00,
        SYNC_ONE_DONE_EVT_I, CAPTURE_ONE_EVT_I, TIMER_TWO_MATCH_EVT_I,
        TIMER_ONE_OVERFLOW_EVT_I};
    // Events are OR-ed after the write so a set beats a same-cycle clear
    assign base = (ack && AVS_ADDRESS_I == {IDX_PERIPHERAL_FLAGS_A, 2'b00})
        ? AVS_WRITEDATA_I[7:0] : fa_q;
    assign req = |(fa_q & en_q) & (ctl_q[0] | ctl_q[1]);
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            fa_q <= 8'h00;
            en_q <= 8'h00;
            ctl_q <= 2'b00;
        end else begin
            fa_q <= ((base & 8'hcf) | ev
                | {2'b00, UART_ONE_RX_FULL_I, UART_ONE_TX_EMPTY_I, 4'h0})
                & keep;
            if (ack && AVS_ADDRESS_I == {IDX_PERIPHERAL_ENABLE_A, 2'b00})
                en_q <= AVS_WRITEDATA_I[7:0] & keep;
            if (ack && AVS_ADDRESS_I == {IDX_INTERRUPT_CONTROL, 2'b00})
                ctl_q <= AVS_WRITEDATA_I[1:0];
        end
    end

    // ==========
    // Sequences and assertions
    sequence s_req;
        $rose(AVS_READ_I | AVS_WRITE_I);
    endsequence
    sequence s_ack;
        !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
    endsequence
    sequence s_rd(idx);
        AVS_READ_I && AVS_WAITREQUEST_O && AVS_ADDRESS_I == {idx, 2'b00};
    endsequence

    a_ack_after_one: assert property (s_req |=> s_ack)
        else $error("late ack");
    a_ack_has_req: assert property (
        !AVS_WAITREQUEST_O |-> $past(AVS_READ_I | AVS_WRITE_I))
        else $error("stray ack");
    a_rdata_top_zero: assert property (
        !AVS_WAITREQUEST_O |-> AVS_READDATA_O[31:8] == 24'h0)
        else $error("rdata high bits");
    a_rdata_holds: assert property (
        AVS_WAITREQUEST_O && $past(AVS_WAITREQUEST_O)
        |-> $stable(AVS_READDATA_O))
        else $error("rdata moved");
    a_irq_follows_model: assert property (
        PERIPH_IRQ_O == $past(req))
        else $error("irq mismatch");
    a_irq_gate_off: assert property (
        !(ctl_q[0] | ctl_q[1]) |=> !PERIPH_IRQ_O)
        else $error("irq ungated");
    a_evt_to_irq: assert property (
        TIMER_ONE_OVERFLOW_EVT_I && en_q[0] && (|ctl_q) && !ack
        |-> ##2 PERIPH_IRQ_O)
        else $error("no irq");
    a_sys_bit_four: assert property (
        s_rd(IDX_SYSTEM_EVENT_FLAGS) |=> !AVS_READDATA_O[4])
        else $error("bit 4 set");
    a_uart_mirror: assert property (
        s_rd(IDX_SERIAL_MISC_FLAGS) |=> AVS_READDATA_O[5:4]
        == $past({UART_TWO_RX_FULL_I, UART_TWO_TX_EMPTY_I}, 2))
        else $error("level flags");
endmodule // pifb_bank_monitor

bind pifb_bank pifb_bank_monitor #(.SMALL_PACKAGE(SMALL_PACKAGE)) u_mon (.*);

// *** sim/pifb_evt_model.sv ***
// Peripheral event source model: one-cycle pulses on command
`timescale 1ns/100ps
module pifb_evt_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Command from the bench
    input wire logic fire_i,
    input wire logic [5:0] sel_i,
    // Eight event lines per flag register
    output logic [39:0] evt_o
);
    // Registered so the pulse never races the bench's own edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            evt_o <= 40'h0;
        end else begin
            evt_o <= fire_i ? (40'h1 << sel_i) : 40'h0;
        end
    end
endmodule // pifb_evt_model
